// *** src/spv_consts.vh ***
// constants for the serial program/verify port
`ifndef SPV_CONSTS_VH
`define SPV_CONSTS_VH

// ==========================================
// address map
`define SPV_ADDR_USER_ID 16'h8000
`define SPV_ADDR_PART_ID 16'h8006
`define SPV_ADDR_CFG1 16'h8007
`define SPV_ADDR_CFG2 16'h8008
`define SPV_CFG_SPACE_BIT 15
`define SPV_USER_ID_COUNT 4

// ==========================================
// low address nibble of each configuration location
`define SPV_IDX_ID0 4'h0
`define SPV_IDX_ID1 4'h1
`define SPV_IDX_ID2 4'h2
`define SPV_IDX_ID3 4'h3
`define SPV_IDX_PART 4'h6
`define SPV_IDX_CFG1 4'h7
`define SPV_IDX_CFG2 4'h8

// ==========================================
// word layout and values
`define SPV_WORD_W 14
`define SPV_BLANK 14'h3fff
`define SPV_CFG2_ONES 14'h01ec
`define SPV_CP_BIT 7

// ==========================================
// serial framing
`define SPV_CMD_W 6
`define SPV_FRAME_W 16
`define SPV_CMD_LAST 5'h05
`define SPV_FRAME_LAST 5'h0f

// ==========================================
// command codes
`define SPV_CMD_LOAD_CFG 6'h00
`define SPV_CMD_LOAD_DATA 6'h02
`define SPV_CMD_READ_DATA 6'h04
`define SPV_CMD_INC_ADDR 6'h06
`define SPV_CMD_BEGIN_PROG 6'h08
`define SPV_CMD_BULK_ERASE 6'h09
`define SPV_CMD_RESET_ADDR 6'h16

`endif

// *** src/spv_pin_sync.v ***
// two-flop synchronisers for the programming pins
module spv_pin_sync #(
   parameter W = 3
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   // ==========================================
   // one pair of flops per pin, each bit owned by its own process
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               meta <= 1'b0;
               stable <= 1'b0;
            end else begin
               meta <= i_async[g];
               stable <= meta;
            end
         end
         // only the second flop reaches the logic
         assign o_sync[g] = stable;
      end
   endgenerate
endmodule // spv_pin_sync

// *** src/spv_port.v ***
// serial program/verify port with program and configuration memory
`include "spv_consts.vh"

module spv_port #(
   parameter PM_AW = 13,
   parameter [8:0] PART_CODE = 9'h0a5, // arbitrary value
   parameter [4:0] REV_CODE = 5'h01 // arbitrary value
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_prog_serial_clock,
   input wire i_prog_serial_data,
   input wire i_master_clear_input,
   output reg o_prog_serial_data,
   output reg o_prog_serial_data_oe,
   output reg o_core_reset,
   output reg o_io_hiz
);
   localparam [1:0] S_CMD = 2'h0;
   localparam [1:0] S_RX = 2'h1;
   localparam [1:0] S_TX = 2'h2;
   localparam [1:0] S_ERASE = 2'h3;
   localparam PM_DEPTH = 1 << PM_AW;

   wire [2:0] pins_s;
   wire sclk_s;
   wire din_s;
   wire hv_s;
   reg sclk_d;
   reg in_mode;
   reg [1:0] state;
   reg [4:0] cnt;
   reg [`SPV_CMD_W-1:0] cmd_sh;
   reg [`SPV_FRAME_W-1:0] sh;
   reg [15:0] pc;
   reg [`SPV_WORD_W-1:0] latch;
   reg [`SPV_WORD_W-1:0] user_id [0:`SPV_USER_ID_COUNT-1];
   reg [`SPV_WORD_W-1:0] cfg1;
   reg [`SPV_WORD_W-1:0] cfg2;
   reg [PM_AW-1:0] ecnt;
   reg [`SPV_WORD_W-1:0] pmem [0:PM_DEPTH-1];
   reg [`SPV_WORD_W-1:0] rd_word;
   integer i;

   // ==========================================
   // pin sampling
   spv_pin_sync #(
      .W(3)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_master_clear_input, i_prog_serial_data, i_prog_serial_clock}),
      .o_sync(pins_s)
   );

   assign sclk_s = pins_s[0];
   assign din_s = pins_s[1];
   assign hv_s = pins_s[2];

   // clock edges seen by the programmer clock, only inside the mode
   wire rise = in_mode & hv_s & sclk_s & ~sclk_d;
   wire fall = in_mode & hv_s & ~sclk_s & sclk_d;
   wire [`SPV_CMD_W-1:0] cmd_now = {din_s, cmd_sh[`SPV_CMD_W-1:1]};
   wire cmd_done = fall & (state == S_CMD) & (cnt == `SPV_CMD_LAST);
   wire in_cfg = pc[`SPV_CFG_SPACE_BIT];
   wire cp_on = ~cfg1[`SPV_CP_BIT];
   wire do_prog = cmd_done & (cmd_now == `SPV_CMD_BEGIN_PROG);
   wire do_erase = cmd_done & (cmd_now == `SPV_CMD_BULK_ERASE);
   wire [3:0] cfg_idx = pc[3:0];

   // ==========================================
   // read multiplexer
   always @* begin
      rd_word = {`SPV_WORD_W{1'b0}};
      if (!in_cfg) begin
         if (!cp_on) begin
            rd_word = pmem[pc[PM_AW-1:0]];
         end
      end else begin
         case (cfg_idx)
            `SPV_IDX_ID0, `SPV_IDX_ID1, `SPV_IDX_ID2, `SPV_IDX_ID3: begin
               rd_word = user_id[cfg_idx[1:0]];
            end
            `SPV_IDX_PART: rd_word = {PART_CODE, REV_CODE};
            `SPV_IDX_CFG1: rd_word = cfg1;
            `SPV_IDX_CFG2: rd_word = cfg2 | `SPV_CFG2_ONES;
            default: rd_word = {`SPV_WORD_W{1'b0}};
         endcase
      end
   end

   // ==========================================
   // program memory write port, array without reset
   always @(posedge i_clk) begin
      if (state == S_ERASE) begin
         pmem[ecnt] <= `SPV_BLANK;
      end else if (do_prog && !in_cfg && !cp_on) begin
         pmem[pc[PM_AW-1:0]] <= latch;
      end
   end

   // ==========================================
   // mode tracking and reset outputs
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         in_mode <= 1'b0;
         sclk_d <= 1'b0;
         o_core_reset <= 1'b0;
         o_io_hiz <= 1'b0;
      end else begin
         in_mode <= hv_s;
         sclk_d <= sclk_s;
         o_core_reset <= hv_s;
         o_io_hiz <= hv_s;
      end
   end

   // ==========================================
   // serial engine, address and latch
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= S_CMD;
         cnt <= 5'h00;
         cmd_sh <= {`SPV_CMD_W{1'b0}};
         sh <= {`SPV_FRAME_W{1'b0}};
         pc <= 16'h0000;
         latch <= `SPV_BLANK;
         ecnt <= {PM_AW{1'b0}};
         o_prog_serial_data <= 1'b0;
         o_prog_serial_data_oe <= 1'b0;
      end else if (!in_mode || !hv_s) begin
         // outside the mode, or leaving it: idle, pin floats, address zero
         state <= S_CMD;
         cnt <= 5'h00;
         pc <= 16'h0000;
         o_prog_serial_data <= 1'b0;
         o_prog_serial_data_oe <= 1'b0;
      end else begin
         case (state)
            S_CMD: begin
               if (fall) begin
                  cmd_sh <= cmd_now;
                  cnt <= cnt + 5'h01;
                  if (cnt == `SPV_CMD_LAST) begin
                     cnt <= 5'h00;
                     case (cmd_now)
                        `SPV_CMD_LOAD_CFG: begin
                           pc <= `SPV_ADDR_USER_ID;
                           state <= S_RX;
                        end
                        `SPV_CMD_LOAD_DATA: state <= S_RX;
                        `SPV_CMD_READ_DATA: begin
                           sh <= {1'b0, rd_word, 1'b0};
                           o_prog_serial_data_oe <= 1'b1;
                           state <= S_TX;
                        end
                        `SPV_CMD_INC_ADDR: pc <= pc + 16'h0001;
                        `SPV_CMD_RESET_ADDR: pc <= 16'h0000;
                        `SPV_CMD_BULK_ERASE: begin
                           ecnt <= {PM_AW{1'b0}};
                           state <= S_ERASE;
                        end
                        default: state <= S_CMD;
                     endcase
                  end
               end
            end
            S_RX: begin
               if (fall) begin
                  sh <= {din_s, sh[`SPV_FRAME_W-1:1]};
                  cnt <= cnt + 5'h01;
                  if (cnt == `SPV_FRAME_LAST) begin
                     latch <= sh[`SPV_FRAME_W-1:2]; // drop start and stop bits
                     cnt <= 5'h00;
                     state <= S_CMD;
                  end
               end
            end
            S_TX: begin
               if (rise) begin
                  o_prog_serial_data <= sh[0];
                  sh <= {1'b0, sh[`SPV_FRAME_W-1:1]};
               end
               if (fall) begin
                  cnt <= cnt + 5'h01;
                  if (cnt == `SPV_FRAME_LAST) begin
                     cnt <= 5'h00;
                     o_prog_serial_data <= 1'b0;
                     o_prog_serial_data_oe <= 1'b0;
                     state <= S_CMD;
                  end
               end
            end
            S_ERASE: begin
               ecnt <= ecnt + {{(PM_AW-1){1'b0}}, 1'b1};
               if (&ecnt) begin
                  state <= S_CMD;
               end
            end
            default: state <= S_CMD;
         endcase
      end
   end

   // ==========================================
   // configuration words; the identity word has no storage at all
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (i = 0; i < `SPV_USER_ID_COUNT; i = i + 1) begin
            user_id[i] <= `SPV_BLANK;
         end
         cfg1 <= `SPV_BLANK;
         cfg2 <= `SPV_BLANK;
      end else if (do_erase) begin
         cfg1 <= `SPV_BLANK;
         cfg2 <= `SPV_BLANK;
         if (in_cfg) begin
            for (i = 0; i < `SPV_USER_ID_COUNT; i = i + 1) begin
               user_id[i] <= `SPV_BLANK;
            end
         end
      end else if (do_prog && in_cfg) begin
         case (cfg_idx)
            `SPV_IDX_ID0, `SPV_IDX_ID1, `SPV_IDX_ID2, `SPV_IDX_ID3: begin
               user_id[cfg_idx[1:0]] <= latch;
            end
            `SPV_IDX_CFG1: cfg1 <= latch;
            `SPV_IDX_CFG2: cfg2 <= latch;
            default: cfg1 <= cfg1;
         endcase
      end
   end
endmodule // spv_port

// *** tb/spv_monitor.sv ***
// checker for the serial program/verify port pins
module spv_monitor (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_prog_serial_clock,
   input wire i_master_clear_input,
   input wire o_prog_serial_data,
   input wire o_prog_serial_data_oe,
   input wire o_core_reset,
   input wire o_io_hiz
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ==========================================
   // mode entry and exit
   property p_entry;
      $rose(i_master_clear_input) |-> ##2 !o_core_reset ##1 o_core_reset;
   endproperty
   a_entry: assert property (p_entry) else $error("late core reset");
   property p_exit;
      $fell(i_master_clear_input) |-> ##2 o_core_reset ##1 !o_core_reset;
   endproperty
   a_exit: assert property (p_exit) else $error("late core release");
   property p_hiz;
      o_io_hiz == $past(i_master_clear_input, 3);
   endproperty
   a_hiz: assert property (p_hiz) else $error("pins not floated");
   // ==========================================
   // data pin driving
   property p_oe_mode;
      o_prog_serial_data_oe |-> o_core_reset;
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("drive outside mode");
   property p_idle;
      !i_master_clear_input [*5] |-> !o_prog_serial_data_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("drive while idle");
   property p_oe_start;
      $rose(o_prog_serial_data_oe) |-> !o_prog_serial_data;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("bad start bit");
   property p_change;
      $changed(o_prog_serial_data) |-> i_prog_serial_clock;
   endproperty
   a_change: assert property (p_change) else $error("data moved on low");
   property p_oe_fall;
      $fell(o_prog_serial_data_oe) |-> !i_prog_serial_clock;
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("early release");
endmodule // spv_monitor

bind spv_port spv_monitor u_spv_monitor (.i_clk, .i_rst_b, .i_prog_serial_clock,
   .i_master_clear_input, .o_prog_serial_data, .o_prog_serial_data_oe, .o_core_reset, .o_io_hiz);

// *** tb/spv_prog_model.sv ***
// programmer model: clocks the serial link and shifts bits both ways
module spv_prog_model (
   input wire i_clk,
   input wire i_oe,
   input wire i_dev_data,
   output logic o_sclk,
   output wire o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b1;
   logic d = 1'b0;
   initial o_sclk = 1'b0;
   // released line shows the inverse of the last bit
   assign o_pin = i_oe ? i_dev_data : (drv ? d : ~d);
   // one bit: change after rise, sample at fall, 320 ns period
   task automatic bit_io(input logic b, output logic s);
      @(posedge i_clk);
      o_sclk <= 1'b1;
      d <= b;
      repeat (4) @(posedge i_clk);
      s = o_pin;
      o_sclk <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
   task automatic cmd(input logic [5:0] c);
      logic s;
      for (int i = 0; i < 6; i++) bit_io(c[i], s);
   endtask
   task automatic load(input logic [13:0] v);
      logic [15:0] fr;
      logic s;
      fr = {1'b0, v, 1'b0};
      for (int i = 0; i < 16; i++) bit_io(fr[i], s);
   endtask
   task automatic read(output logic [15:0] fr);
      drv <= 1'b0;
      for (int i = 0; i < 16; i++) bit_io(i[0], fr[i]);
      drv <= 1'b1;
   endtask
endmodule // spv_prog_model

// *** tb/spv_port_tb.sv ***
// self-checking bench for the serial program/verify port
`include "spv_consts.vh"
module spv_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [13:0] IDW = {9'h1c3, 5'h0b}; // arbitrary part and revision
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic master_clear_input = 1'b0;
   wire sclk, pin, dout, oe, core_rst, hiz;
   int failures = 0;
   int n_tests = 0;
   logic [15:0] f;
   always #20 clk = ~clk;
   spv_port #(.PM_AW(6), .PART_CODE(IDW[13:5]), .REV_CODE(IDW[4:0])) u_spv_port (
      .i_clk(clk), .i_rst_b(rst_b), .i_prog_serial_clock(sclk), .i_prog_serial_data(pin),
      .i_master_clear_input(master_clear_input), .o_prog_serial_data(dout), .o_prog_serial_data_oe(oe),
      .o_core_reset(core_rst), .o_io_hiz(hiz));
   spv_prog_model u_spv_prog_model (.i_clk(clk), .i_oe(oe), .i_dev_data(dout),
      .o_sclk(sclk), .o_pin(pin));
   // ==========================================
   // helpers
   task close_out;
      if (failures == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] c, input logic [13:0] v);
      u_spv_prog_model.cmd(c);
      u_spv_prog_model.load(v);
      u_spv_prog_model.cmd(`SPV_CMD_BEGIN_PROG);
   endtask
   task automatic rd(input logic [13:0] v);
      u_spv_prog_model.cmd(`SPV_CMD_READ_DATA);
      u_spv_prog_model.read(f);
      chk(f, {1'b0, v, 1'b0});
   endtask
   task automatic inc(input int n);
      repeat (n) u_spv_prog_model.cmd(`SPV_CMD_INC_ADDR);
   endtask
   task automatic to_ids;
      u_spv_prog_model.cmd(`SPV_CMD_LOAD_CFG);
      u_spv_prog_model.load(14'h0000);
   endtask
   // ==========================================
   // scenarios
   task t_entry;
      chk(16'({oe, core_rst, hiz}), 16'h0000);
      master_clear_input <= 1'b1;
      repeat (10) @(posedge clk);
      chk(16'({oe, core_rst, hiz}), 16'h0003);
   endtask
   task t_pmem;
      wr(`SPV_CMD_LOAD_DATA, 14'h2a5c);
      rd(14'h2a5c);
   endtask
   task t_ids;
      for (int i = 0; i < 4; i++) begin
         if (i > 0) inc(1);
         wr(i == 0 ? `SPV_CMD_LOAD_CFG : `SPV_CMD_LOAD_DATA, 14'h3a50 ^ 14'(i));
      end
      to_ids();
      for (int i = 0; i < 4; i++) begin
         rd(14'h3a50 ^ 14'(i));
         inc(1);
      end
   endtask
   task t_identity;
      inc(2);
      rd(IDW);
      wr(`SPV_CMD_LOAD_DATA, 14'h0000);
      rd(IDW);
   endtask
   task t_cfg_protect;
      inc(1);
      wr(`SPV_CMD_LOAD_DATA, 14'h3f7f);
      inc(1);
      wr(`SPV_CMD_LOAD_DATA, 14'h0000);
      rd(14'h01ec);
      to_ids();
      rd(14'h3a50);
      u_spv_prog_model.cmd(`SPV_CMD_RESET_ADDR);
      rd(14'h0000);
   endtask
   task t_erase_exit;
      to_ids();
      u_spv_prog_model.cmd(`SPV_CMD_BULK_ERASE);
      repeat (100) @(posedge clk);
      rd(`SPV_BLANK);
      inc(6);
      rd(IDW);
      master_clear_input <= 1'b0;
      repeat (10) @(posedge clk);
      chk(16'({oe, core_rst, hiz}), 16'h0000);
      master_clear_input <= 1'b1;
      repeat (10) @(posedge clk);
      rd(`SPV_BLANK);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      t_entry();
      t_pmem();
      t_ids();
      t_identity();
      t_cfg_protect();
      t_erase_exit();
      close_out();
   end
   initial begin
      #3000000;
      failures++;
      close_out();
   end
endmodule // spv_port_tb
